/* File: shared/qtm_pkg.sv */
package qtm_pkg;
	// Printed register indices; byte address is four times the index
	localparam logic [19:0] IDX_CTRL_CH0 = 20'hf_ff80;
	localparam logic [19:0] IDX_CTRL_CH1 = 20'hf_ff81;
	localparam logic [19:0] IDX_STATUS_CH0 = 20'hf_ff82;
	localparam logic [19:0] IDX_STATUS_CH1 = 20'hf_ff83;
	localparam logic [19:0] IDX_CONST_A_CH0 = 20'hf_ff84;
	localparam logic [19:0] IDX_CONST_A_CH1 = 20'hf_ff85;
	localparam logic [19:0] IDX_CONST_B_CH0 = 20'hf_ff86;
	localparam logic [19:0] IDX_CONST_B_CH1 = 20'hf_ff87;
	localparam logic [19:0] IDX_COUNT_CH0 = 20'hf_ff88;
	localparam logic [19:0] IDX_COUNT_CH1 = 20'hf_ff89;
	localparam logic [19:0] IDX_CTRL_CH2 = 20'hf_ff90;
	localparam logic [19:0] IDX_CTRL_CH3 = 20'hf_ff91;
	localparam logic [19:0] IDX_STATUS_CH2 = 20'hf_ff92;
	localparam logic [19:0] IDX_STATUS_CH3 = 20'hf_ff93;
	localparam logic [19:0] IDX_CONST_A_CH2 = 20'hf_ff94;
	localparam logic [19:0] IDX_CONST_A_CH3 = 20'hf_ff95;
	localparam logic [19:0] IDX_CONST_B_CH2 = 20'hf_ff96;
	localparam logic [19:0] IDX_CONST_B_CH3 = 20'hf_ff97;
	localparam logic [19:0] IDX_COUNT_CH2 = 20'hf_ff98;
	localparam logic [19:0] IDX_COUNT_CH3 = 20'hf_ff99;
	// Word (pair) access windows, index = base + kind
	localparam logic [19:0] IDX_PAIR_G0 = 20'hf_ffa0;
	localparam logic [19:0] IDX_PAIR_G1 = 20'hf_ffb0;
	localparam int unsigned NKIND = 5;
	// Register kinds in one channel
	localparam logic [2:0] K_CTRL = 3'h0;
	localparam logic [2:0] K_STAT = 3'h1;
	localparam logic [2:0] K_CA = 3'h2;
	localparam logic [2:0] K_CB = 3'h3;
	localparam logic [2:0] K_CNT = 3'h4;
	// Control fields
	localparam int unsigned CT_IE_B = 7;
	localparam int unsigned CT_IE_A = 6;
	localparam int unsigned CT_IE_OV = 5;
	localparam int unsigned CT_CLR_LO = 3;
	localparam int unsigned CT_CKS_LO = 0;
	// Status fields
	localparam int unsigned ST_MFB = 7;
	localparam int unsigned ST_MFA = 6;
	localparam int unsigned ST_OVF = 5;
	localparam int unsigned ST_AUX = 4;
	localparam int unsigned ST_OSB_LO = 2;
	localparam int unsigned ST_OSA_LO = 0;
	// Clear select codes
	localparam logic [1:0] CLR_OFF = 2'h0;
	localparam logic [1:0] CLR_A = 2'h1;
	localparam logic [1:0] CLR_B_CAP = 2'h2;
	localparam logic [1:0] CLR_CAP = 2'h3;
	// Clock select codes
	localparam logic [2:0] CKS_STOP = 3'h0;
	localparam logic [2:0] CKS_D8 = 3'h1;
	localparam logic [2:0] CKS_D64 = 3'h2;
	localparam logic [2:0] CKS_D8K = 3'h3;
	localparam logic [2:0] CKS_CASC = 3'h4;
	localparam logic [2:0] CKS_FALL = 3'h5;
	localparam logic [2:0] CKS_RISE = 3'h6;
	localparam logic [2:0] CKS_BOTH = 3'h7;
	// Output actions
	localparam logic [1:0] OUT_KEEP = 2'h0;
	localparam logic [1:0] OUT_LOW = 2'h1;
	localparam logic [1:0] OUT_HIGH = 2'h2;
	localparam logic [1:0] OUT_TOG = 2'h3;
	// Prescaler divisions
	localparam int unsigned DIV_FAST = 8;
	localparam int unsigned DIV_MID = 64;
	localparam int unsigned DIV_SLOW = 8192;
	localparam int unsigned PRE_W = 13;
	// Reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_CNT = 8'h00;
	localparam logic [7:0] RST_CONST = 8'hff;
	localparam logic [7:0] RST_STAT = 8'h00;
	localparam logic [7:0] RST_STAT_CH2 = 8'h10;
	localparam logic [1:0] RST_OE = 2'h3;

	typedef struct packed {
		logic ext_clock_pin_ch0;
		logic ext_clock_pin_ch1;
		logic ext_clock_pin_ch2;
		logic ext_clock_pin_ch3;
		logic compare_capture_pin_ch1;
		logic compare_capture_pin_ch3;
	} qtm_pins_in_t;

	typedef struct packed {
		logic compare_out_pin_ch0;
		logic compare_out_pin_ch2;
		logic compare_capture_pin_ch1;
		logic compare_capture_pin_ch1_oe;
		logic compare_capture_pin_ch3;
		logic compare_capture_pin_ch3_oe;
	} qtm_pins_out_t;

	typedef struct packed {
		logic hit;
		logic pair;
		logic [2:0] kind;
		logic [1:0] ch;
	} qtm_dec_t;

	typedef struct packed {
		logic [3:0][7:0] cnt;
		logic [3:0][7:0] ca;
		logic [3:0][7:0] cb;
		logic [3:0][7:0] ctrl;
		logic [3:0][7:0] stat;
		logic [3:0] eqa;
		logic [3:0] eqb;
		logic [3:0] ovf_ev;
		logic [3:0] cma_ev;
		logic [3:0] pin;
		logic [1:0] oe;
		logic [PRE_W-1:0] pre;
		logic [3:0] clk_m;
		logic [3:0] clk_s;
		logic [3:0] clk_p;
		logic [1:0] cap_m;
		logic [1:0] cap_s;
		logic [1:0] cap_p;
		logic rdy;
		logic err;
		logic [31:0] rdata;
		logic adc;
		logic [7:0] irq;
	} qtm_state_t;
endpackage

/* File: src/qtm_timer.sv */
// Local design decision: register access over APB.
module qtm_timer #(
	parameter int unsigned DIV_SLOW_CNT = qtm_pkg::DIV_SLOW
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [21:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	input wire qtm_pkg::qtm_pins_in_t pins_i,
	output qtm_pkg::qtm_pins_out_t pins_o,
	output logic adc_start_o,
	output logic [7:0] irq_o
);
	import qtm_pkg::*;

	// Last prescaler step; the slow divide wraps the shared counter
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(DIV_SLOW_CNT - 1);
	// Index of every single register, by channel and kind
	localparam logic [19:0] IDX_MAP [4][NKIND] = '{
		'{IDX_CTRL_CH0, IDX_STATUS_CH0, IDX_CONST_A_CH0, IDX_CONST_B_CH0, IDX_COUNT_CH0},
		'{IDX_CTRL_CH1, IDX_STATUS_CH1, IDX_CONST_A_CH1, IDX_CONST_B_CH1, IDX_COUNT_CH1},
		'{IDX_CTRL_CH2, IDX_STATUS_CH2, IDX_CONST_A_CH2, IDX_CONST_B_CH2, IDX_COUNT_CH2},
		'{IDX_CTRL_CH3, IDX_STATUS_CH3, IDX_CONST_A_CH3, IDX_CONST_B_CH3, IDX_COUNT_CH3}
	};

	// Whole block state and its next value
	qtm_state_t s_q;
	qtm_state_t s_d;

	// Address decode over the 20-bit register index
	// address bits 21:2
	function automatic qtm_dec_t decode(input logic [19:0] idx);
		qtm_dec_t r;
		r = '0;
		for (int c = 0; c < 4; c++) begin
			for (int k = 0; k < NKIND; k++) begin
				if (idx == IDX_MAP[c][k]) begin
					r.hit = 1'b1;
					r.kind = 3'(k);
					r.ch = 2'(c);
				end
			end
		end
		for (int k = 0; k < NKIND; k++) begin
			if (idx == IDX_PAIR_G0 + 20'(k) || idx == IDX_PAIR_G1 + 20'(k)) begin
				r.hit = 1'b1;
				r.pair = 1'b1;
				r.kind = 3'(k);
				r.ch = (idx[7:4] == IDX_PAIR_G1[7:4]) ? 2'h2 : 2'h0;
			end
		end
		return r;
	endfunction

	// One register byte as software sees it
	function automatic logic [7:0] reg_byte(input qtm_state_t s, input logic [2:0] kind,
			input logic [1:0] ch);
		logic [7:0] v;
		v = 8'h00;
		unique case (kind)
			K_CTRL: v = s.ctrl[ch];
			K_STAT: v = s.stat[ch];
			K_CA: v = s.ca[ch];
			K_CB: v = s.cb[ch];
			K_CNT: v = s.cnt[ch];
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Apply a two-bit output action to the pin level
	function automatic logic out_act(input logic lvl, input logic [1:0] act);
		logic r;
		r = lvl;
		unique case (act)
			OUT_KEEP: r = lvl;
			OUT_LOW: r = 1'b0;
			OUT_HIGH: r = 1'b1;
			OUT_TOG: r = ~lvl;
		endcase
		return r;
	endfunction

	// Merge two simultaneous output actions: toggle beats high beats low
	function automatic logic [1:0] act_merge(input logic [1:0] a, input logic [1:0] b);
		logic [1:0] r;
		r = a;
		if (b > a) begin
			r = b;
		end
		return r;
	endfunction

	// Other channel of the same group; keeps cascade indices in range
	function automatic int mate(input int c);
		return c ^ 1;
	endfunction

	// Next-state logic for the whole block
	always_comb begin
		qtm_dec_t dec;
		logic tk8;
		logic tk64;
		logic tk8k;
		logic [3:0] rise;
		logic [3:0] fall;
		logic [3:0] tick;
		logic [3:0] cma;
		logic [3:0] cmb;
		logic [3:0] capt;
		logic [3:0] ovf;
		logic [3:0] eqa;
		logic [3:0] eqb;
		logic [3:0] clr;
		logic [1:0] cr;
		logic [1:0] cf;
		logic [2:0] cks;
		logic [1:0] csel;
		logic [1:0] oisel;
		logic ice;
		logic wr;
		logic [7:0] wb;
		logic [1:0] wc;
		logic [1:0] act;
		int e;
		int o;
		s_d = s_q;
		dec = decode(paddr_i[21:2]);
		tk8 = 1'b0;
		tk64 = 1'b0;
		tk8k = 1'b0;
		rise = '0;
		fall = '0;
		tick = '0;
		cma = '0;
		cmb = '0;
		capt = '0;
		ovf = '0;
		eqa = '0;
		eqb = '0;
		clr = '0;
		cr = '0;
		cf = '0;
		cks = CKS_STOP;
		csel = CLR_OFF;
		oisel = '0;
		ice = 1'b0;
		wr = 1'b0;
		wb = 8'h00;
		wc = '0;
		act = OUT_KEEP;
		e = 0;
		o = 0;

		// Shared prescaler; the slow divide must stay a multiple of 64
		// internal clocks
		s_d.pre = (s_q.pre == PRE_LAST) ? '0 : s_q.pre + 1'b1;
		tk8 = s_q.pre[2:0] == 3'h7;
		tk64 = s_q.pre[5:0] == 6'h3f;
		tk8k = s_q.pre == PRE_LAST;

		// Pin levels move with no regard to our clock; two flops tame them
		// Two-stage synchronisers, edges read only from the later stages
		// sync and edge
		s_d.clk_m = {pins_i.ext_clock_pin_ch3, pins_i.ext_clock_pin_ch2,
			pins_i.ext_clock_pin_ch1, pins_i.ext_clock_pin_ch0};
		s_d.clk_s = s_q.clk_m;
		s_d.clk_p = s_q.clk_s;
		s_d.cap_m = {pins_i.compare_capture_pin_ch3, pins_i.compare_capture_pin_ch1};
		s_d.cap_s = s_q.cap_m;
		s_d.cap_p = s_q.cap_s;
		rise = s_q.clk_s & ~s_q.clk_p;
		fall = ~s_q.clk_s & s_q.clk_p;
		cr = s_q.cap_s & ~s_q.cap_p;
		cf = ~s_q.cap_s & s_q.cap_p;

		// Per-channel count, match and clear
		// pairs 0-1, 2-3
		for (int c = 0; c < 4; c++) begin
			cks = s_q.ctrl[c][CT_CKS_LO +: 3];
			csel = s_q.ctrl[c][CT_CLR_LO +: 2];
			unique case (cks)
				CKS_STOP: tick[c] = 1'b0;
				CKS_D8: tick[c] = tk8;
				CKS_D64: tick[c] = tk64;
				CKS_D8K: tick[c] = tk8k;
				// odd counts even match A
				// Cascade sources are last cycle's events, one clock behind
				CKS_CASC: tick[c] = c[0] ? s_q.cma_ev[mate(c)] : s_q.ovf_ev[mate(c)];
				CKS_FALL: tick[c] = fall[c];
				CKS_RISE: tick[c] = rise[c];
				CKS_BOTH: tick[c] = rise[c] | fall[c];
			endcase
			// Capture only on odd channels with capture enabled
			// edge select
			ice = c[0] && s_q.stat[c][ST_AUX];
			oisel = s_q.stat[c][ST_OSB_LO +: 2];
			if (ice) begin
				unique case (oisel)
					2'h0: capt[c] = cr[c/2];
					2'h1: capt[c] = cf[c/2];
					default: capt[c] = cr[c/2] | cf[c/2];
				endcase
			end
			// Compare the count as it stands; a match fires on its rising
			// continuous compare
			eqa[c] = s_q.cnt[c] == s_q.ca[c];
			eqb[c] = s_q.cnt[c] == s_q.cb[c];
			cma[c] = eqa[c] & ~s_q.eqa[c];
			cmb[c] = ice ? capt[c] : (eqb[c] & ~s_q.eqb[c]);
			// Clear happens where the next count would be: period is N+1
			// clear sources
			unique case (csel)
				CLR_OFF: clr[c] = 1'b0;
				CLR_A: clr[c] = tick[c] & eqa[c];
				CLR_B_CAP: clr[c] = ice ? capt[c] : (tick[c] & eqb[c]);
				CLR_CAP: clr[c] = capt[c];
			endcase
			if (clr[c]) begin
				s_d.cnt[c] = 8'h00;
			end else if (tick[c]) begin
				s_d.cnt[c] = s_q.cnt[c] + 8'h01;
				ovf[c] = s_q.cnt[c] == 8'hff;
			end
			// Simultaneous actions merge: toggle beats high beats low
			// two match signals
			act = OUT_KEEP;
			if (cma[c]) begin
				act = s_q.stat[c][ST_OSA_LO +: 2];
			end
			if (cmb[c] && !ice && s_q.stat[c][ST_OSB_LO +: 2] != OUT_KEEP) begin
				act = act_merge(act, s_q.stat[c][ST_OSB_LO +: 2]);
			end
			s_d.pin[c] = out_act(s_q.pin[c], act);
		end
		s_d.eqa = eqa;
		s_d.eqb = eqb;
		s_d.ovf_ev = ovf;
		s_d.cma_ev = cma;

		// Bus slave: first access cycle answers, second commits the write
		// Read data is latched early so it stands while ready is high
		// A write lands only at the edge that also samples ready high
		if (psel_i && penable_i && !s_q.rdy) begin
			s_d.rdy = 1'b1;
			s_d.err = ~dec.hit;
			s_d.rdata = 32'h0000_0000;
			if (dec.hit && dec.pair) begin
				s_d.rdata[15:8] = reg_byte(s_q, dec.kind, dec.ch);
				s_d.rdata[7:0] = reg_byte(s_q, dec.kind, dec.ch | 2'h1);
			end else if (dec.hit) begin
				s_d.rdata[7:0] = reg_byte(s_q, dec.kind, dec.ch);
			end
		end else if (s_q.rdy) begin
			s_d.rdy = 1'b0;
			s_d.err = 1'b0;
			wr = psel_i & penable_i & pwrite_i & dec.hit;
		end

		// Register writes; a bus write to a counter beats its count
		// Strobe 1 gates the even byte of a pair, strobe 0 the odd or single
		for (int b = 0; b < 2; b++) begin
			wc = dec.pair ? (dec.ch | 2'(1 - b)) : dec.ch;
			wb = (dec.pair && b == 1) ? pwdata_i[15:8] : pwdata_i[7:0];
			if (wr && pstrb_i[b] && (dec.pair || b == 0)) begin
				unique case (dec.kind)
					K_CTRL: s_d.ctrl[wc] = wb;
					K_STAT: begin
						s_d.stat[wc][7:5] = s_q.stat[wc][7:5] & wb[7:5];
						s_d.stat[wc][4:0] = wb[4:0];
						if (wc == 2'h2) begin
							s_d.stat[wc][ST_AUX] = RST_STAT_CH2[ST_AUX];
						end
					end
					K_CA: s_d.ca[wc] = wb;
					K_CB: s_d.cb[wc] = wb;
					K_CNT: s_d.cnt[wc] = wb;
					default: s_d.err = s_d.err;
				endcase
			end
		end

		// Hardware flag sets win over a clearing write in the same cycle
		// Flags only fall by a written zero; nothing else lowers them
		for (int c = 0; c < 4; c++) begin
			if (cma[c]) begin
				s_d.stat[c][ST_MFA] = 1'b1;
			end
			if (cmb[c]) begin
				s_d.stat[c][ST_MFB] = 1'b1;
			end
			if (ovf[c]) begin
				s_d.stat[c][ST_OVF] = 1'b1;
			end
		end

		// Pin direction follows the capture enable about to be stored
		// pin direction
		s_d.oe[0] = ~s_d.stat[1][ST_AUX];
		s_d.oe[1] = ~s_d.stat[3][ST_AUX];

		// Capture beats a bus write to constant B; 16-bit pair grabs both
		// capture copy
		for (int g = 0; g < 2; g++) begin
			e = 2 * g;
			o = e + 1;
			if (capt[o]) begin
				s_d.cb[o] = s_q.cnt[o];
				if (s_q.ctrl[e][CT_CKS_LO +: 3] == CKS_CASC) begin
					s_d.cb[e] = s_q.cnt[e];
				end
			end
		end

		// Converter start from channel 0 match A when enabled
		// converter trigger
		s_d.adc = cma[0] & s_q.stat[0][ST_AUX];

		// Requests are levels; they fall once software clears the flag
		// Request lines: own vectors for A/B of 0 and 2, rest shared
		// twelve sources
		s_d.irq[0] = s_q.stat[0][ST_MFA] & s_q.ctrl[0][CT_IE_A];
		s_d.irq[1] = s_q.stat[0][ST_MFB] & s_q.ctrl[0][CT_IE_B];
		s_d.irq[2] = s_q.stat[2][ST_MFA] & s_q.ctrl[2][CT_IE_A];
		s_d.irq[3] = s_q.stat[2][ST_MFB] & s_q.ctrl[2][CT_IE_B];
		s_d.irq[4] = (s_q.stat[1][ST_MFA] & s_q.ctrl[1][CT_IE_A])
			| (s_q.stat[1][ST_MFB] & s_q.ctrl[1][CT_IE_B]);
		s_d.irq[5] = (s_q.stat[3][ST_MFA] & s_q.ctrl[3][CT_IE_A])
			| (s_q.stat[3][ST_MFB] & s_q.ctrl[3][CT_IE_B]);
		s_d.irq[6] = (s_q.stat[0][ST_OVF] & s_q.ctrl[0][CT_IE_OV])
			| (s_q.stat[1][ST_OVF] & s_q.ctrl[1][CT_IE_OV]);
		s_d.irq[7] = (s_q.stat[2][ST_OVF] & s_q.ctrl[2][CT_IE_OV])
			| (s_q.stat[3][ST_OVF] & s_q.ctrl[3][CT_IE_OV]);
	end

	// Async reset clears all other state to zero and loads the reset constants
	// State register
	// reset values
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.cnt <= {4{RST_CNT}};
			s_q.ctrl <= {4{RST_CTRL}};
			s_q.ca <= {4{RST_CONST}};
			s_q.cb <= {4{RST_CONST}};
			s_q.stat <= {RST_STAT, RST_STAT_CH2, RST_STAT, RST_STAT};
			s_q.oe <= RST_OE;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from state flops
	// pin set
	assign pins_o.compare_out_pin_ch0 = s_q.pin[0];
	assign pins_o.compare_capture_pin_ch1 = s_q.pin[1];
	assign pins_o.compare_capture_pin_ch1_oe = s_q.oe[0];
	assign pins_o.compare_out_pin_ch2 = s_q.pin[2];
	assign pins_o.compare_capture_pin_ch3 = s_q.pin[3];
	assign pins_o.compare_capture_pin_ch3_oe = s_q.oe[1];
	assign pready_o = s_q.rdy;
	assign prdata_o = s_q.rdata;
	assign pslverr_o = s_q.err;
	assign adc_start_o = s_q.adc;
	assign irq_o = s_q.irq;
endmodule

/* File: dv/qtm_timer_props.sv */
module qtm_props
	import qtm_pkg::*;
#(
	parameter int unsigned DIV_SLOW_CNT = 8192
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [21:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	input wire qtm_pkg::qtm_pins_in_t pins_i,
	input wire qtm_pkg::qtm_pins_out_t pins_o,
	input wire logic adc_start_o,
	input wire logic [7:0] irq_o
);
	logic [3:0] grp;
	logic [3:0] k;
	logic mapped;
	logic wr_done;
	// Ten singles per group, five kinds per pair window
	assign grp = paddr_i[9:6];
	assign k = paddr_i[5:2];
	assign mapped = paddr_i[21:10] == 12'hfff &&
		(grp[3:1] == 3'h4 && k <= 4'h9 || grp[3:1] == 3'h5 && k <= 4'h4);
	assign wr_done = pready_o && pwrite_i;
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Bus transfer steps
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_access;
		psel_i && penable_i && !pready_o;
	endsequence
	a_ready_answer: assert property (s_setup ##1 s_access |=> pready_o)
		else $error("no ready after access");
	a_ready_once: assert property (pready_o |=> !pready_o)
		else $error("ready too long");
	a_ready_cause: assert property (!(psel_i && penable_i) |=> !pready_o)
		else $error("ready without access");
	a_err_decode: assert property (pready_o |-> pslverr_o == !mapped)
		else $error("wrong error response");
	a_err_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_read_width: assert property (pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0000 &&
		(grp[1] || prdata_o[15:8] == 8'h00))
		else $error("read width wrong");
	a_data_hold: assert property ($changed(prdata_o) |-> pready_o)
		else $error("read data moved");
	a_adc_pulse: assert property (adc_start_o |=> !adc_start_o)
		else $error("trigger not a pulse");
	a_oe_by_write: assert property ($changed({pins_o.compare_capture_pin_ch1_oe,
		pins_o.compare_capture_pin_ch3_oe}) |-> $past(wr_done) || $past(wr_done, 2))
		else $error("pin direction moved");
endmodule

bind qtm_timer qtm_props #(.DIV_SLOW_CNT(DIV_SLOW_CNT)) u_props (.clk_i(clk_i), .rst_i(rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o),
	.pslverr_o(pslverr_o), .pins_i(pins_i), .pins_o(pins_o), .adc_start_o(adc_start_o),
	.irq_o(irq_o));

/* File: dv/qtm_pin_model.sv */
module qtm_pin_model
	import qtm_pkg::*;
(
	input wire logic clk_i,
	input wire qtm_pkg::qtm_pins_out_t dev_i,
	output qtm_pkg::qtm_pins_in_t pins_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] drv_q = 6'h00;
	assign pins_o = {drv_q[5:2],
		dev_i.compare_capture_pin_ch1_oe ? dev_i.compare_capture_pin_ch1 : drv_q[1],
		dev_i.compare_capture_pin_ch3_oe ? dev_i.compare_capture_pin_ch3 : drv_q[0]};
	// Pins idle low between bursts; wide pulses so the sync never misses one
	task automatic pulse(input int b, input int n);
		repeat (n) begin
			@(posedge clk_i);
			drv_q[b] <= 1'b1;
			repeat (4) @(posedge clk_i);
			drv_q[b] <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask
endmodule

/* File: dv/qtm_timer_test.sv */
module qtm_timer_test
	import qtm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [21:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	logic pready;
	logic pslverr;
	logic adc;
	logic [31:0] prdata;
	logic [7:0] irq;
	qtm_pins_in_t pin_in;
	qtm_pins_out_t pin_out;
	int bad_count = 0;
	int cmp_count = 0;
	logic [31:0] rd_v;
	logic err_v;
	logic [2:0] md [3] = '{CKS_RISE, CKS_BOTH, CKS_FALL};
	logic [7:0] ex [3] = '{8'h05, 8'h0f, 8'h14};

	always #10 clk = ~clk;

	// Short slow divider keeps the run brief
	qtm_timer #(.DIV_SLOW_CNT(128)) DUT (.clk_i(clk), .rst_i(rst), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
		.pins_i(pin_in), .pins_o(pin_out), .adc_start_o(adc), .irq_o(irq));
	qtm_pin_model PM (.clk_i(clk), .dev_i(pin_out), .pins_o(pin_in));

	task automatic end_of_test();
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One transfer; an idle cycle after keeps drivers from colliding
	task automatic apb(input logic w, input logic [19:0] idx, input logic [31:0] wd);
		int n;
		logic rdy_v;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		rdy_v = 1'b0;
		// Answer looked at mid-cycle where it has settled, then the edge passes
		do begin
			@(negedge clk);
			rdy_v = pready;
			rd_v = prdata;
			err_v = pslverr;
			@(posedge clk);
			n++;
		end while (rdy_v !== 1'b1 && n < 50);
		if (rdy_v !== 1'b1) begin
			bad_count++;
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rchk(input logic [19:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(rd_v, exp);
	endtask

	initial begin
		logic [7:0] e;
		int k;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Reset values of both groups
		for (int g = 0; g < 2; g++) begin
			for (k = 0; k < 10; k++) begin
				e = (k inside {[4:7]}) ? 8'hff : ((g == 1 && k == 2) ? 8'h10 : 8'h00);
				rchk(20'hf_ff80 + 20'(g * 16 + k), {24'h00_0000, e}); // reset
			end
		end
		rchk(20'hf_ff8a, 32'h0000_0000); // unmapped
		chk(32'(err_v), 32'h0000_0001); // error
		apb(1'b1, IDX_STATUS_CH1, 32'h0000_00e0); // ones ignored
		rchk(IDX_STATUS_CH1, 32'h0000_0000); // flags clear
		// Pair access, even channel high
		apb(1'b1, IDX_PAIR_G1 + 20'(K_CB), 32'h0000_1234); // pair
		rchk(IDX_CONST_B_CH2, 32'h0000_0012); // even
		rchk(IDX_CONST_B_CH3, 32'h0000_0034); // odd
		rchk(IDX_PAIR_G1 + 20'(K_CB), 32'h0000_1234); // pair
		pstrb <= 4'h1;
		apb(1'b1, IDX_PAIR_G1 + 20'(K_CB), 32'h0000_5678); // odd byte only
		pstrb <= 4'hf;
		rchk(IDX_PAIR_G1 + 20'(K_CB), 32'h0000_1278); // strobe gate
		// Match at FF, wrap, trigger, output high
		apb(1'b1, IDX_COUNT_CH0, 32'h0000_00fd);
		apb(1'b1, IDX_STATUS_CH0, 32'h0000_0012);
		apb(1'b1, IDX_CTRL_CH0, 32'h0000_00e1); // divide by 8
		k = 0;
		while (adc !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		chk(32'(k < 100), 32'h0000_0001); // trigger
		if (k >= 100) begin
			end_of_test();
		end
		repeat (20) @(posedge clk);
		apb(1'b1, IDX_CTRL_CH0, 32'h0000_00e0);
		rchk(IDX_STATUS_CH0, 32'h0000_00f2); // flags
		chk(32'(irq & 8'h43), 32'h0000_0043); // sources
		chk(32'(pin_out.compare_out_pin_ch0), 32'h0000_0001); // output
		apb(1'b1, IDX_STATUS_CH0, 32'h0000_0012); // zero clears
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0000_0000); // requests fall
		rchk(IDX_STATUS_CH0, 32'h0000_0012); // cleared
		// Clear on match A bounds the count
		apb(1'b1, IDX_CONST_A_CH2, 32'h0000_0003);
		apb(1'b1, IDX_CTRL_CH2, 32'h0000_0009); // clear on A
		for (k = 0; k < 8; k++) begin
			apb(1'b0, IDX_COUNT_CH2, 32'h0000_0000);
			chk(32'(rd_v <= 32'h0000_0003), 32'h0000_0001); // bounded
			repeat (5) @(posedge clk);
		end
		rchk(IDX_STATUS_CH2, 32'h0000_0050); // flag A only
		// External clock edge modes
		for (k = 0; k < 3; k++) begin
			apb(1'b1, IDX_CTRL_CH1, 32'(md[k])); // edge mode
			PM.pulse(4, 5);
			rchk(IDX_COUNT_CH1, 32'(ex[k])); // counted edges
		end
		// Group 0 as one 16-bit counter: odd overflow ticks the even half
		apb(1'b1, IDX_COUNT_CH0, 32'h0000_0000);
		apb(1'b1, IDX_COUNT_CH1, 32'h0000_00fe);
		apb(1'b1, IDX_CTRL_CH0, 32'(CKS_CASC));
		apb(1'b1, IDX_CTRL_CH1, 32'(CKS_RISE));
		PM.pulse(4, 3);
		rchk(IDX_PAIR_G0 + 20'(K_CNT), 32'h0000_0101); // 16-bit count
		// Odd channel counts even match A; even clears on A every two edges
		apb(1'b1, IDX_CONST_A_CH0, 32'h0000_0001);
		apb(1'b1, IDX_COUNT_CH0, 32'h0000_0000);
		apb(1'b1, IDX_CTRL_CH0, 32'h0000_000e);
		apb(1'b1, IDX_COUNT_CH1, 32'h0000_0000);
		apb(1'b1, IDX_CTRL_CH1, 32'(CKS_CASC));
		PM.pulse(5, 4);
		rchk(IDX_COUNT_CH1, 32'h0000_0002); // match count
		// Capture copies the count
		apb(1'b1, IDX_STATUS_CH3, 32'h0000_0010);
		apb(1'b1, IDX_CTRL_CH3, 32'(CKS_RISE));
		PM.pulse(2, 7);
		PM.pulse(0, 1);
		rchk(IDX_CONST_B_CH3, 32'h0000_0007); // captured
		rchk(IDX_STATUS_CH3, 32'h0000_0090); // flag B
		chk(32'(pin_out.compare_capture_pin_ch3_oe), 32'h0000_0000); // input
		end_of_test();
	end
endmodule
